/* src/ifeb_bank.sv */
// Purpose: Interrupt flag, enable and priority bank with APB access
// Assumes: Event pulses come from logic on clk, one cycle each
// Notes: Zero wait states; read data captured in the setup cycle
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "ifeb_regs.svh"

module ifeb_bank
    import ifeb_pkg::*;
#(
    parameter bit HAS_CAN = 1'b1,
    parameter bit HAS_DAC = 1'b1
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Source event pulses, index 16 * register + bit
    input wire ifeb_vec_t src_event,
    // Towards the interrupt sequencer
    output ifeb_vec_t req_fwd,
    output ifeb_vec_t flag_out,
    // Bank interrupt
    output logic irq
);

    localparam ifeb_vec_t IMPL = `IFEB_IMPL;
    localparam ifeb_vec_t NO_CAN = HAS_CAN ? 80'h0 : `IFEB_CAN_MASK;
    localparam ifeb_vec_t NO_DAC = HAS_DAC ? 80'h0 : `IFEB_DAC_MASK;
    localparam ifeb_vec_t ALLOW = IMPL & ~NO_CAN & ~NO_DAC;

    ifeb_vec_t flag_q;
    ifeb_vec_t en_q;
    ifeb_vec_t next_flag;
    ifeb_vec_t next_en;
    ifeb_vec_t prio_nz;
    ifeb_vec_t ev_impl;
    ifeb_prio_t prio_q [`IFEB_NUM_SRC];
    ifeb_grp_t sts_q;
    ifeb_grp_t msk_q;
    ifeb_grp_t next_sts;
    ifeb_grp_t evt_grp;
    ifeb_grp_t sel_flag;
    ifeb_grp_t sel_en;
    ifeb_grp_t wr_flag;
    ifeb_grp_t wr_en;
    logic [`IFEB_NUM_PW-1:0] sel_prio;
    logic [`IFEB_NUM_PW-1:0] wr_prio;
    logic sel_sts;
    logic sel_msk;
    logic setup_ph;
    logic wr_acc;
    logic hit;
    logic [31:0] rd_mux;

    // Bus phases
    // No wait states; every access ends in its first access cycle
    assign setup_ph = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    assign pready = psel & penable;

    // Status and mask decode
    assign sel_sts = paddr == `IFEB_STS_OFF;
    assign sel_msk = paddr == `IFEB_MSK_OFF;

    // Flag and enable register decode
    // shared bit layout
    genvar g;
    generate
        for (g = 0; g < `IFEB_NUM_GRP; g++)
        begin : g_grp
            assign sel_flag[g] = paddr == `IFEB_FLAG_OFF + 8'(g * 4);
            assign sel_en[g] = paddr == `IFEB_EN_OFF + 8'(g * 4);
            assign wr_flag[g] = wr_acc & sel_flag[g];
            assign wr_en[g] = wr_acc & sel_en[g];
            assign evt_grp[g] = |ev_impl[g*16 +: 16];
        end
    endgenerate

    // Priority register decode, eight fields a word
    genvar w;
    generate
        for (w = 0; w < `IFEB_NUM_PW; w++)
        begin : g_pw
            assign sel_prio[w] = paddr == `IFEB_PRIO_OFF + 8'(w * 4);
            assign wr_prio[w] = wr_acc & sel_prio[w];
        end
    endgenerate

    assign hit = |{sel_flag, sel_en, sel_prio, sel_sts, sel_msk};

    assign ev_impl = src_event & IMPL;

    // Per source flag, enable and priority
    genvar s;
    generate
        for (s = 0; s < `IFEB_NUM_SRC; s++)
        begin : g_src
            localparam int G = s / 16;
            localparam int B = s % 16;
            localparam int W = s / 8;
            localparam int F = (s % 8) * `IFEB_PRIO_PITCH;
            assign next_flag[s] = IMPL[s]
                & (src_event[s] | (wr_flag[G] ? pwdata[B] : flag_q[s]));
            assign next_en[s] = ALLOW[s]
                & (wr_en[G] ? pwdata[B] : en_q[s]);
            assign prio_nz[s] = |prio_q[s];
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                    prio_q[s] <= `IFEB_PRIO_RST;
                else if (wr_prio[W])
                    prio_q[s] <= pwdata[F +: `IFEB_PRIO_W];
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flag_q <= '0;
            en_q <= '0;
        end
        else
        begin
            flag_q <= next_flag;
            en_q <= next_en;
        end
    end

    assign req_fwd = flag_q & en_q & prio_nz;
    assign flag_out = flag_q;

    // Sticky bank events, write one to clear; a new event wins
    assign next_sts = evt_grp
        | (sts_q & ~(wr_acc & sel_sts ? pwdata[4:0] : 5'h00));

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sts_q <= '0;
            msk_q <= '0;
        end
        else
        begin
            sts_q <= next_sts;
            if (wr_acc && sel_msk)
                msk_q <= pwdata[`IFEB_EVT_W-1:0];
        end
    end

    assign irq = |(sts_q & msk_q);

    // Read selection; unassigned and unmapped bits read 0
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        for (int i = 0; i < `IFEB_NUM_GRP; i++)
        begin
            if (sel_flag[i])
                rd_mux[15:0] = flag_q[i*16 +: 16];
            if (sel_en[i])
                rd_mux[15:0] = en_q[i*16 +: 16];
        end
        for (int j = 0; j < `IFEB_NUM_PW; j++)
        begin
            if (sel_prio[j])
            begin
                for (int k = 0; k < 8; k++)
                begin
                    if (IMPL[j*8 + k])
                        rd_mux[k*4 +: 3] = prio_q[j*8 + k];
                end
            end
        end
        if (sel_sts)
            rd_mux[4:0] = sts_q;
        if (sel_msk)
            rd_mux[4:0] = msk_q;
    end

    // Read data captured in setup so prdata leaves a flop
    // Unmapped accesses still complete; the error bit flags the miss
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prdata <= '0;
            pslverr <= 1'b0;
        end
        else if (setup_ph)
        begin
            prdata <= rd_mux;
            pslverr <= ~hit;
        end
    end

    // Assertion helpers
    logic [15:0] h_wd0;
    assign h_wd0 = pwdata[15:0] & `IFEB_IMPL0;

    sequence s_wr_acc;
        psel && penable && pwrite;
    endsequence

    sequence s_rd_setup;
        psel && !penable && !pwrite;
    endsequence

    property p_flag_set;
        @(posedge clk) disable iff (!arst_n)
        |ev_impl |=> ((flag_q & $past(ev_impl)) == $past(ev_impl));
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("event did not set its flag");

    property p_flag_hold;
        @(posedge clk) disable iff (!arst_n)
        !(|ev_impl) && !(|wr_flag) |=> $stable(flag_q);
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("flag changed without event or write");

    property p_en_gate;
        @(posedge clk) disable iff (!arst_n)
        wr_en[0] && pwdata[15:0] == 16'h0000 |=> req_fwd[15:0] == 16'h0000;
    endproperty
    a_en_gate: assert property (p_en_gate)
        else $error("request passed a cleared enable");

    property p_reset_zero;
        @(posedge clk) !arst_n |-> flag_q == '0 && en_q == '0;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("flag or enable not zero in reset");

    property p_sw_write;
        @(posedge clk) disable iff (!arst_n)
        s_wr_acc ##0 sel_flag[0] && !(|ev_impl[15:0])
        |=> flag_q[15:0] == $past(h_wd0);
    endproperty
    a_sw_write: assert property (p_sw_write)
        else $error("flag write not stored");

    property p_unimpl;
        @(posedge clk) disable iff (!arst_n)
        (flag_q & ~IMPL) == '0 && (en_q & ~ALLOW) == '0;
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("unassigned bit became set");

    property p_unimpl_rd;
        @(posedge clk) disable iff (!arst_n)
        s_rd_setup ##0 sel_flag[0] |=> prdata[31:15] == 17'h0_0000;
    endproperty
    a_unimpl_rd: assert property (p_unimpl_rd)
        else $error("unassigned bit read nonzero");

    property p_no_can;
        @(posedge clk) disable iff (!arst_n)
        HAS_CAN || (en_q & `IFEB_CAN_MASK) == '0;
    endproperty
    a_no_can: assert property (p_no_can)
        else $error("CAN source enabled without controller");

    property p_no_dac;
        @(posedge clk) disable iff (!arst_n)
        HAS_DAC || (en_q & `IFEB_DAC_MASK) == '0;
    endproperty
    a_no_dac: assert property (p_no_dac)
        else $error("DAC source enabled without converter");

    property p_en_read;
        @(posedge clk) disable iff (!arst_n)
        s_rd_setup ##0 sel_en[1] |=> prdata[15:0] == $past(en_q[31:16]);
    endproperty
    a_en_read: assert property (p_en_read)
        else $error("enable read misplaced");

    property p_prio_zero;
        @(posedge clk) disable iff (!arst_n)
        wr_prio[0] && pwdata == 32'h0000_0000 |=> req_fwd[7:0] == 8'h00;
    endproperty
    a_prio_zero: assert property (p_prio_zero)
        else $error("zero priority source forwarded");

    // Event to request path, with enable and priority left alone
    property p_fwd;
        @(posedge clk) disable iff (!arst_n)
        ev_impl[0] && en_q[0] && prio_nz[0] && !wr_en[0] && !wr_prio[0]
        |=> req_fwd[0];
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("armed request not forwarded");

    sequence s_clash;
        wr_flag[0] && ev_impl[0] && !pwdata[0];
    endsequence

    property p_set_wins;
        @(posedge clk) disable iff (!arst_n)
        s_clash |=> flag_q[0] ##1 1'b1;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("write clear beat hardware set");

    property p_irq;
        @(posedge clk) disable iff (!arst_n)
        |(ev_impl[15:0]) && msk_q[0] |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("masked-in bank event gave no interrupt");

    property p_slverr;
        @(posedge clk) disable iff (!arst_n)
        s_rd_setup ##0 !hit |=> pslverr && prdata == 32'h0000_0000;
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("unmapped read gave data or no error");

    // Status clear only when no new event competes
    property p_sts_clear;
        @(posedge clk) disable iff (!arst_n)
        s_wr_acc ##0 sel_sts && pwdata[0] && !evt_grp[0] |=> !sts_q[0];
    endproperty
    a_sts_clear: assert property (p_sts_clear)
        else $error("status bit not cleared by write one");

    property p_prio_rd;
        @(posedge clk) disable iff (!arst_n)
        s_rd_setup ##0 sel_prio[0]
        |=> prdata[2:0] == $past(prio_q[0]) && !prdata[3];
    endproperty
    a_prio_rd: assert property (p_prio_rd)
        else $error("priority field read misplaced");

endmodule

/* src/ifeb_regs.svh */
// Purpose: Offsets, field layouts and reset values of the flag bank
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Source index is 16 * register + bit position
`ifndef IFEB_REGS_SVH
`define IFEB_REGS_SVH

// Register counts
`define IFEB_NUM_SRC 80
`define IFEB_NUM_GRP 5
`define IFEB_NUM_PW 10

// Byte offsets
`define IFEB_FLAG_OFF 8'h00
`define IFEB_EN_OFF 8'h20
`define IFEB_PRIO_OFF 8'h40
`define IFEB_STS_OFF 8'h80
`define IFEB_MSK_OFF 8'h84

// Implemented bits of each flag and enable register
`define IFEB_IMPL0 16'h7FFF
`define IFEB_IMPL1 16'hFFDF
`define IFEB_IMPL2 16'h601F
`define IFEB_IMPL3 16'h7800
`define IFEB_IMPL4 16'hC07E
`define IFEB_IMPL {`IFEB_IMPL4, `IFEB_IMPL3, `IFEB_IMPL2, \
    `IFEB_IMPL1, `IFEB_IMPL0}

// Sources that exist only with the optional controllers
`define IFEB_CAN_MASK {16'h0040, 16'h0000, 16'h000C, 32'h0000_0000}
`define IFEB_DAC_MASK {16'hC000, 64'h0000_0000_0000_0000}

// Priority field layout and reset values
`define IFEB_PRIO_W 3
`define IFEB_PRIO_PITCH 4
`define IFEB_PRIO_RST 3'h4
`define IFEB_EVT_W 5

`endif

/* src/ifeb_pkg.sv */
// Purpose: Types shared by the interrupt flag and enable bank
// Assumes: Constants come from ifeb_regs.svh
// Notes: Types only
package ifeb_pkg;

    typedef logic [79:0] ifeb_vec_t;
    typedef logic [15:0] ifeb_word_t;
    typedef logic [2:0] ifeb_prio_t;
    typedef logic [4:0] ifeb_grp_t;

endpackage

/* testbench/ifeb_src_model.sv */
// Purpose: Peripheral event sources feeding the flag bank
// Assumes: Pulses are one clk cycle, launched after a rising edge
// Notes: One pulse at a time; a second caller would clear the first
`timescale 1ns/1ps

module ifeb_src_model
    import ifeb_pkg::*;
(
    // Clock
    input wire logic clk,
    // Event pulses towards the bank
    output ifeb_vec_t src_event
);
    initial src_event = '0;

    // Held for exactly one edge, so the bank sees a single event
    task automatic pulse(input int idx);
        @(posedge clk);
        src_event[idx] <= 1'b1;
        @(posedge clk);
        src_event <= '0;
    endtask
endmodule

/* testbench/tb_top.sv */
// Purpose: Self-checking bench for the interrupt flag and enable bank
// Assumes: Variant without the optional CAN and audio DAC controllers
// Notes: APB master tasks; expectations from the register header
`timescale 1ns/1ps
`include "ifeb_regs.svh"

module tb_top
    import ifeb_pkg::*;
;
    localparam ifeb_vec_t IMPL = `IFEB_IMPL;
    localparam ifeb_vec_t OPT = `IFEB_CAN_MASK | `IFEB_DAC_MASK;
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic rerr;
    ifeb_vec_t src_event, req_fwd, flag_out;
    int num_errors = 0;
    int cmp_count = 0;

    ifeb_bank #(.HAS_CAN(1'b0), .HAS_DAC(1'b0)) i_dut (.clk(clk),
        .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_event(src_event), .req_fwd(req_fwd),
        .flag_out(flag_out), .irq(irq));
    ifeb_src_model i_src (.clk(clk), .src_event(src_event));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Hold the request until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let the access edge settle before callers look at outputs
        @(negedge clk);
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [15:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdata, {16'h0000, exp});
    endtask

    task end_sim;
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (4000) @(posedge clk);
        num_errors++;
        end_sim;
    end

    initial
    begin
        arst_n = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        for (int g = 0; g < 5; g++)
        begin
            chk_reg(8'(`IFEB_FLAG_OFF + 4 * g), 16'h0000);
            chk_reg(8'(`IFEB_EN_OFF + 4 * g), 16'h0000);
            apb(1'b1, 8'(`IFEB_FLAG_OFF + 4 * g), 32'hFFFF_FFFF);
            chk_reg(8'(`IFEB_FLAG_OFF + 4 * g), IMPL[16 * g +: 16]);
            apb(1'b1, 8'(`IFEB_FLAG_OFF + 4 * g), 32'h0000_0000);
            chk_reg(8'(`IFEB_FLAG_OFF + 4 * g), 16'h0000);
            apb(1'b1, 8'(`IFEB_EN_OFF + 4 * g), 32'hFFFF_FFFF);
            chk_reg(8'(`IFEB_EN_OFF + 4 * g),
                IMPL[16 * g +: 16] & ~OPT[16 * g +: 16]);
        end
        apb(1'b1, 8'(`IFEB_EN_OFF), 32'h0000_0000);
        apb(1'b0, 8'(`IFEB_PRIO_OFF), 32'h0000_0000);
        chk(rdata, {8{1'b0, `IFEB_PRIO_RST}});
        apb(1'b1, 8'(`IFEB_STS_OFF), 32'h0000_001F);
        apb(1'b1, 8'(`IFEB_MSK_OFF), 32'h0000_001F);
        // Disabled source: flag set, nothing forwarded
        i_src.pulse(0);
        @(negedge clk);
        chk(32'(flag_out), 32'h0000_0001);
        chk(32'(req_fwd[0]), 32'h0000_0000);
        chk(32'(irq), 32'h0000_0001);
        chk_reg(8'(`IFEB_STS_OFF), 16'h0001);
        apb(1'b1, 8'(`IFEB_EN_OFF), 32'h0000_0001);
        chk(32'(req_fwd[0]), 32'h0000_0001);
        i_src.pulse(0);
        @(negedge clk);
        chk(32'(req_fwd[0]), 32'h0000_0001);
        apb(1'b1, 8'(`IFEB_PRIO_OFF), 32'h0000_0000);
        chk(32'(req_fwd[0]), 32'h0000_0000);
        apb(1'b1, 8'(`IFEB_MSK_OFF), 32'h0000_0000);
        chk(32'(irq), 32'h0000_0000);
        apb(1'b1, 8'(`IFEB_STS_OFF), 32'h0000_0001);
        chk_reg(8'(`IFEB_STS_OFF), 16'h0000);
        apb(1'b1, 8'(`IFEB_FLAG_OFF), 32'h0000_0000);
        chk(32'(flag_out[0]), 32'h0000_0000);
        // Event lands on the very edge that writes zero
        fork
            apb(1'b1, 8'(`IFEB_FLAG_OFF), 32'h0000_0000);
            begin
                @(posedge clk);
                i_src.pulse(0);
            end
        join
        @(negedge clk);
        chk(32'(flag_out[0]), 32'h0000_0001);
        i_src.pulse(35);
        @(negedge clk);
        chk(32'(flag_out[35]), 32'h0000_0001);
        chk(32'(req_fwd[35]), 32'h0000_0000);
        i_src.pulse(21);
        @(negedge clk);
        chk(32'(flag_out[21]), 32'h0000_0000);
        apb(1'b0, 8'h34, 32'h0000_0000);
        chk({rdata[30:0], rerr}, 32'h0000_0001);
        end_sim;
    end
endmodule
